// ---- modbus_master.sv ----
/* Link master model: sends a six-byte request plus check word and
   collects the reply. Assumes the slave's byte-level link ports. */
`timescale 1ns/1ps
module modbus_master (
  input wire logic clk_sys, // Clock
  output logic [7:0] rx_data, // Request byte
  output logic rx_valid, // Byte strobe
  output logic rx_frame_end, // Frame end strobe
  input wire logic [7:0] tx_data, // Reply byte
  input wire logic tx_valid, // Reply valid
  output logic tx_ready // Reply taken
);
  logic slow = 1'b0;
  logic [7:0] r[$];
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_frame_end = 1'b0;
    tx_ready = 1'b1;
  end
  // Bytes go out back to back, check word low byte first.
  task automatic xfer(input logic [47:0] f);
    logic [7:0] b;
    logic [15:0] c;
    c = 16'hffff;
    r = {};
    for (int i = 7; i >= 0; i--) begin
      b = (i > 1) ? f[8*i-16 +: 8] : c[8-8*i +: 8];
      c ^= (i > 1) ? {8'h00, b} : 16'h0000;
      if (i > 1) repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      @(negedge clk_sys);
      rx_data = b;
      rx_valid = 1'b1;
    end
    @(negedge clk_sys);
    rx_valid = 1'b0;
    rx_frame_end = 1'b1;
    @(negedge clk_sys);
    rx_frame_end = 1'b0;
    // The idle data line keeps moving so a stale byte never looks valid.
    repeat (80) begin
      @(posedge clk_sys);
      if (tx_valid === 1'b1 && tx_ready) r.push_back(tx_data);
      @(negedge clk_sys);
      rx_data = ~rx_data;
      tx_ready = slow ? ~tx_ready : 1'b1;
    end
  endtask : xfer
endmodule : modbus_master

// ---- motor_starter_regs.sv ----
/*
 * Serial slave command interpreter and register file of a reversing
 * soft-start motor starter: frame check, coils, holding and input
 * registers, stored configuration and link timeout.
 * Assumes an external character receiver that delivers bytes and marks
 * the end of each frame, and a transmitter that accepts bytes on ready.
 */
`timescale 1ns/1ps

// Contract
// - Eight bit rates, 8N2, address 1..99
// - Accept function codes 03 04 05 06 10
// - Coil 0 switches clockwise run
// - Coil 1 switches anticlockwise run
// - Coil 2 resets, coil 3 saves
// - Control word and run word, values 0..2
// - Nominal current 50..500 centiamps
// - Ramp-up start voltage 30..80 percent
// - Ramp-up time 0..100 tenths
// - Ramp-down end voltage 30..80 percent
// - Ramp-down time 0..100 tenths
// - Save request copies configuration to storage
// - Only holding registers 2..6 are saved
// - Power-up loads stored configuration
// - No frames received during 50 ms save
// - Input register 0 reports failure code
// - Input register 1 reports device state
// - Input registers 2, 3 report current, load
// - Address and rate sampled at power-up only
// - Protection trip stops motor, code 8
// - Missing phase gives code 4, clearable
module motor_starter_regs #(
  parameter int unsigned SAVE_HOLD_CYC = starter_pkg::SAVE_HOLD_CYC,
  parameter int unsigned CYC_PER_MS = starter_pkg::CYC_PER_MS
) (
  input wire logic clk_sys, // System clock, 10 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [3:0] address_tens_selector, // Address tens switch
  input wire logic [3:0] address_units_selector, // Address units switch
  input wire logic [2:0] baud_selector, // Bit rate switch position
  output logic [2:0] baud_rate_sel, // Latched rate for the UART
  output logic [6:0] slave_address, // Latched own address
  input wire logic [7:0] rx_data, // Received byte
  input wire logic rx_valid, // Received byte strobe
  input wire logic rx_frame_end, // End of frame strobe
  output logic [7:0] tx_data, // Byte to send
  output logic tx_valid, // Byte offered to transmitter
  input wire logic tx_ready, // Transmitter takes the byte
  output logic rx_blocked, // Reception held off by a save
  output logic turn_clockwise, // Clockwise run command
  output logic turn_anticlockwise, // Anticlockwise run command
  output logic device_reset, // Device reset pulse
  output logic save_config, // Store configuration pulse
  output logic [79:0] config_data, // Holding registers 2..6
  input wire logic ee_load_valid, // Stored configuration present
  input wire logic ee_load_bad, // Stored configuration checksum bad
  input wire logic [79:0] ee_load_data, // Stored configuration words
  input wire logic fault_valid, // Fault event strobe
  input wire logic [3:0] fault_code, // Code of the fault event
  input wire logic [2:0] motor_state, // Motor sequencer state 0..5
  input wire logic [15:0] measured_current, // Motor current, centiamps
  input wire logic [15:0] load_percent // Motor load, percent
);

  localparam int unsigned RXC_W = $clog2(starter_pkg::RX_DEPTH) + 1;

  typedef struct packed {
    starter_pkg::phase_t st;
    logic [6:0] slave_addr;
    logic [2:0] baud;
    logic [starter_pkg::N_HOLD-1:0][15:0] hreg;
    logic [3:0] fail;
    logic [starter_pkg::RX_DEPTH-1:0][7:0] rxbuf;
    logic [RXC_W-1:0] rxcnt;
    logic [15:0] rxcrc;
    logic ovf;
    logic [5:0] idx;
    logic [5:0] len;
    logic [7:0] exc;
    logic [3:0] k;
    logic pass;
    logic [15:0] txcrc;
    logic [7:0] tx_data;
    logic tx_valid;
    logic rst_pulse;
    logic save_pend;
    logic save_req;
    logic [31:0] hold_cnt;
    logic [31:0] ms_div;
    logic [15:0] ms_cnt;
  } state_t;

  state_t q_ff;
  state_t nxt_q;

  logic [7:0] fc;
  logic [15:0] start;
  logic [15:0] qty;
  logic [15:0] val;
  logic [15:0] raddr;
  logic [15:0] lim;
  logic [5:0] vi;
  logic [5:0] off;
  logic [3:0] rsel;
  logic [3:0] nreg;
  logic [15:0] word;
  logic [7:0] rbyte;
  logic [7:0] exc_v;
  logic [7:0] sel_sum;
  logic [starter_pkg::N_INPUT-1:0][15:0] ireg;
  logic last;
  logic ok;

  function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                          input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ starter_pkg::CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction : crc_upd

  // Range check of a holding register write.
  function automatic logic valid_val(input logic [3:0] r,
                                     input logic [15:0] v);
    case (r)
      starter_pkg::HR_SYS, starter_pkg::HR_RUN:
        return v <= starter_pkg::CTRL_MAX;
      starter_pkg::HR_CUR: return v >= starter_pkg::CUR_MIN &&
                                  v <= starter_pkg::CUR_MAX;
      starter_pkg::HR_UPV: return v >= starter_pkg::VOLT_MIN &&
                                  v <= starter_pkg::VOLT_MAX;
      starter_pkg::HR_UPT: return v <= starter_pkg::TIME_MAX;
      starter_pkg::HR_DNV: return v >= starter_pkg::VOLT_MIN &&
                                  v <= starter_pkg::VOLT_MAX;
      starter_pkg::HR_DNT: return v <= starter_pkg::TIME_MAX;
      starter_pkg::HR_TOE: return v <= starter_pkg::TOE_MAX;
      starter_pkg::HR_TOV: return v <= starter_pkg::TOV_MAX;
      default: return 1'b0;
    endcase
  endfunction : valid_val

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    nxt_q = q_ff;
    nxt_q.rst_pulse = 1'b0;
    nxt_q.save_req = 1'b0;
    fc = q_ff.rxbuf[1];
    start = {q_ff.rxbuf[2], q_ff.rxbuf[3]};
    qty = {q_ff.rxbuf[4], q_ff.rxbuf[5]};
    vi = starter_pkg::MULTI_HDR + {1'b0, q_ff.k, 1'b0};
    val = (fc == starter_pkg::FC_WR_MULTI) ?
          {q_ff.rxbuf[vi], q_ff.rxbuf[vi + 6'h01]} : qty;
    raddr = start + {12'h000, q_ff.k};
    nreg = (fc == starter_pkg::FC_WR_MULTI) ? qty[3:0] : 4'h1;
    last = (q_ff.k == nreg - 4'h1);
    lim = (fc == starter_pkg::FC_RD_HOLD) ? starter_pkg::HOLD_COUNT :
          starter_pkg::INPUT_COUNT;
    exc_v = 8'h00;
    ok = 1'b0;
    sel_sum = {4'h0, address_tens_selector} * starter_pkg::ADDR_TENS_SCALE
              + {4'h0, address_units_selector};
    // Input registers; any latched failure forces the error state.
    ireg[0] = {12'h000, q_ff.fail};
    ireg[1] = (q_ff.fail != starter_pkg::FAIL_NONE) ?
              starter_pkg::STATE_ERROR : {13'h0000, motor_state};
    ireg[2] = measured_current;
    ireg[3] = load_percent;
    // Response byte at the current transmit index.
    off = q_ff.idx - starter_pkg::READ_HDR;
    rsel = start[3:0] + {1'b0, off[3:1]};
    word = (fc == starter_pkg::FC_RD_HOLD) ? q_ff.hreg[rsel] :
           ireg[rsel[1:0]];
    if (q_ff.exc != 8'h00) begin
      case (q_ff.idx)
        6'h00: rbyte = q_ff.rxbuf[0];
        6'h01: rbyte = fc | starter_pkg::EXC_FLAG;
        default: rbyte = q_ff.exc;
      endcase
    end else if (fc == starter_pkg::FC_RD_HOLD ||
                 fc == starter_pkg::FC_RD_INPUT) begin
      case (q_ff.idx)
        6'h00: rbyte = q_ff.rxbuf[0];
        6'h01: rbyte = fc;
        6'h02: rbyte = {qty[6:0], 1'b0};
        default: rbyte = off[0] ? word[7:0] : word[15:8];
      endcase
    end else begin
      rbyte = q_ff.rxbuf[q_ff.idx];
    end

    case (q_ff.st)
      starter_pkg::ST_INIT: begin
        // Switches are read only here, so later changes wait for power-up.
        nxt_q.slave_addr = sel_sum[6:0];
        nxt_q.baud = baud_selector;
        if (ee_load_valid) begin
          if (ee_load_bad) begin
            nxt_q.fail = starter_pkg::FAIL_EEPROM;
          end else begin
            for (int i = 0; i < starter_pkg::N_SAVED; i++) begin
              nxt_q.hreg[starter_pkg::HR_CUR + i] =
                ee_load_data[i*16 +: 16];
            end
          end
          nxt_q.st = starter_pkg::ST_IDLE;
        end
      end
      starter_pkg::ST_IDLE: begin
        if (rx_valid) begin
          if (q_ff.rxcnt < RXC_W'(starter_pkg::RX_DEPTH)) begin
            nxt_q.rxbuf[q_ff.rxcnt] = rx_data;
            nxt_q.rxcrc = crc_upd(q_ff.rxcrc, rx_data);
            nxt_q.rxcnt = q_ff.rxcnt + RXC_W'(1);
          end else begin
            nxt_q.ovf = 1'b1;
          end
        end
        if (rx_frame_end) begin
          nxt_q.st = starter_pkg::ST_CHECK;
        end
      end
      starter_pkg::ST_CHECK: begin
        nxt_q.st = starter_pkg::ST_IDLE;
        nxt_q.rxcnt = '0;
        nxt_q.rxcrc = starter_pkg::CRC_INIT;
        nxt_q.ovf = 1'b0;
        // A CRC over the whole frame including its check bytes is zero.
        if (!q_ff.ovf && q_ff.rxcnt >= starter_pkg::FRAME_MIN &&
            q_ff.rxcrc == 16'h0000 &&
            q_ff.rxbuf[0] == {1'b0, q_ff.slave_addr} &&
            q_ff.slave_addr >= starter_pkg::ADDR_MIN &&
            q_ff.slave_addr <= starter_pkg::ADDR_MAX) begin
          ok = 1'b1;
          case (fc)
            starter_pkg::FC_RD_HOLD, starter_pkg::FC_RD_INPUT: begin
              if (qty == 16'h0000 || qty > lim) begin
                exc_v = starter_pkg::EXC_VALUE;
              end else if ({1'b0, start} + {1'b0, qty} > {1'b0, lim}) begin
                exc_v = starter_pkg::EXC_ADDR;
              end
            end
            starter_pkg::FC_WR_COIL: begin
              if (start >= starter_pkg::COIL_COUNT) begin
                exc_v = starter_pkg::EXC_ADDR;
              end
            end
            starter_pkg::FC_WR_REG: begin
              if (start >= starter_pkg::HOLD_COUNT) begin
                exc_v = starter_pkg::EXC_ADDR;
              end
            end
            starter_pkg::FC_WR_MULTI: begin
              if (qty == 16'h0000 || qty > starter_pkg::HOLD_COUNT ||
                  q_ff.rxbuf[6] != {qty[6:0], 1'b0} ||
                  q_ff.rxcnt != RXC_W'(starter_pkg::MULTI_FIX +
                                        {qty[4:0], 1'b0})) begin
                exc_v = starter_pkg::EXC_VALUE;
              end else if ({1'b0, start} + {1'b0, qty} >
                           {1'b0, starter_pkg::HOLD_COUNT}) begin
                exc_v = starter_pkg::EXC_ADDR;
              end
            end
            default: exc_v = starter_pkg::EXC_FUNC;
          endcase
        end
        if (ok) begin
          nxt_q.ms_cnt = 16'h0000;
          nxt_q.ms_div = '0;
          nxt_q.exc = exc_v;
          nxt_q.k = 4'h0;
          nxt_q.pass = 1'b0;
          nxt_q.idx = 6'h00;
          nxt_q.txcrc = starter_pkg::CRC_INIT;
          if (exc_v != 8'h00) begin
            nxt_q.len = starter_pkg::EXC_LEN;
            nxt_q.st = starter_pkg::ST_RESP;
          end else if (fc == starter_pkg::FC_RD_HOLD ||
                       fc == starter_pkg::FC_RD_INPUT) begin
            nxt_q.len = starter_pkg::READ_HDR + {qty[4:0], 1'b0};
            nxt_q.st = starter_pkg::ST_RESP;
          end else begin
            nxt_q.st = starter_pkg::ST_EXEC;
          end
        end
      end
      starter_pkg::ST_EXEC: begin
        // First pass checks every value, second pass writes, so a block
        // write with one bad word leaves all registers untouched.
        if (!q_ff.pass) begin
          if ((fc == starter_pkg::FC_WR_COIL) ?
              (val != starter_pkg::COIL_ON &&
               val != starter_pkg::COIL_OFF) :
              !valid_val(raddr[3:0], val)) begin
            nxt_q.exc = starter_pkg::EXC_VALUE;
            nxt_q.len = starter_pkg::EXC_LEN;
            nxt_q.st = starter_pkg::ST_RESP;
          end else if (last) begin
            nxt_q.k = 4'h0;
            nxt_q.pass = 1'b1;
          end else begin
            nxt_q.k = q_ff.k + 4'h1;
          end
        end else begin
          if (fc == starter_pkg::FC_WR_COIL) begin
            case (raddr[1:0])
              starter_pkg::COIL_CW: nxt_q.hreg[starter_pkg::HR_RUN]
                [starter_pkg::RUN_CW_BIT] =
                (val == starter_pkg::COIL_ON);
              starter_pkg::COIL_ACW: nxt_q.hreg[starter_pkg::HR_RUN]
                [starter_pkg::RUN_ACW_BIT] =
                (val == starter_pkg::COIL_ON);
              starter_pkg::COIL_RESET:
                nxt_q.rst_pulse = (val == starter_pkg::COIL_ON);
              default: nxt_q.save_pend = q_ff.save_pend ||
                (val == starter_pkg::COIL_ON);
            endcase
          end else begin
            nxt_q.hreg[raddr[3:0]] = val;
            if (raddr[3:0] == starter_pkg::HR_SYS) begin
              nxt_q.rst_pulse = val[starter_pkg::SYS_RESET_BIT];
              nxt_q.save_pend = q_ff.save_pend ||
                                val[starter_pkg::SYS_SAVE_BIT];
            end
          end
          if (last) begin
            nxt_q.len = starter_pkg::ECHO_LEN;
            nxt_q.st = starter_pkg::ST_RESP;
          end else begin
            nxt_q.k = q_ff.k + 4'h1;
          end
        end
      end
      starter_pkg::ST_RESP: begin
        if (!q_ff.tx_valid || tx_ready) begin
          if (q_ff.idx < q_ff.len) begin
            nxt_q.tx_data = rbyte;
            nxt_q.txcrc = crc_upd(q_ff.txcrc, rbyte);
            nxt_q.tx_valid = 1'b1;
            nxt_q.idx = q_ff.idx + 6'h01;
          end else if (q_ff.idx == q_ff.len) begin
            nxt_q.tx_data = q_ff.txcrc[7:0];
            nxt_q.tx_valid = 1'b1;
            nxt_q.idx = q_ff.idx + 6'h01;
          end else if (q_ff.idx == q_ff.len + 6'h01) begin
            nxt_q.tx_data = q_ff.txcrc[15:8];
            nxt_q.tx_valid = 1'b1;
            nxt_q.idx = q_ff.idx + 6'h01;
          end else begin
            nxt_q.tx_valid = 1'b0;
            nxt_q.st = starter_pkg::ST_IDLE;
            // Storage is written only after the reply has gone out.
            if (q_ff.save_pend) begin
              nxt_q.save_req = 1'b1;
              nxt_q.save_pend = 1'b0;
              nxt_q.hold_cnt = '0;
              nxt_q.st = starter_pkg::ST_BLOCK;
            end
          end
        end
      end
      starter_pkg::ST_BLOCK: begin
        // Bytes arriving here are dropped without being buffered.
        nxt_q.hold_cnt = q_ff.hold_cnt + 32'h00000001;
        if (q_ff.hold_cnt == SAVE_HOLD_CYC - 1) begin
          nxt_q.st = starter_pkg::ST_IDLE;
        end
      end
      default: nxt_q.st = starter_pkg::ST_INIT;
    endcase

    // Link timeout, counted in milliseconds since the last good frame.
    if (q_ff.st != starter_pkg::ST_INIT &&
        nxt_q.ms_cnt != 16'hffff && !ok) begin
      nxt_q.ms_div = q_ff.ms_div + 32'h00000001;
      if (q_ff.ms_div == CYC_PER_MS - 1) begin
        nxt_q.ms_div = '0;
        nxt_q.ms_cnt = q_ff.ms_cnt + 16'h0001;
      end
    end
    if (q_ff.hreg[starter_pkg::HR_TOE] == 16'h0000) begin
      nxt_q.ms_cnt = 16'h0000;
    end else if (q_ff.hreg[starter_pkg::HR_TOV] != 16'h0000 &&
                 q_ff.ms_cnt >= q_ff.hreg[starter_pkg::HR_TOV] &&
                 q_ff.fail == starter_pkg::FAIL_NONE) begin
      nxt_q.fail = starter_pkg::FAIL_LINK;
      nxt_q.hreg[starter_pkg::HR_RUN] = 16'h0000;
    end

    // Acknowledge comes first so a fault in the same cycle is kept.
    if (nxt_q.rst_pulse) begin
      nxt_q.fail = starter_pkg::FAIL_NONE;
    end
    if (fault_valid && fault_code != starter_pkg::FAIL_NONE) begin
      nxt_q.fail = fault_code;
      nxt_q.hreg[starter_pkg::HR_RUN] = 16'h0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q_ff <= '0;
      q_ff.hreg <= starter_pkg::HREG_RST;
      q_ff.rxcrc <= starter_pkg::CRC_INIT;
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  for (genvar g = 0; g < starter_pkg::N_SAVED; g++) begin : g_save
    assign config_data[g*16 +: 16] =
      q_ff.hreg[starter_pkg::HR_CUR + g];
  end

  assign baud_rate_sel = q_ff.baud;
  assign slave_address = q_ff.slave_addr;
  assign tx_data = q_ff.tx_data;
  assign tx_valid = q_ff.tx_valid;
  assign rx_blocked = (q_ff.st == starter_pkg::ST_BLOCK);
  assign turn_clockwise =
    q_ff.hreg[starter_pkg::HR_RUN][starter_pkg::RUN_CW_BIT];
  assign turn_anticlockwise =
    q_ff.hreg[starter_pkg::HR_RUN][starter_pkg::RUN_ACW_BIT];
  assign device_reset = q_ff.rst_pulse;
  assign save_config = q_ff.save_req;

endmodule : motor_starter_regs

// ---- motor_starter_regs_asserts.sv ----
/* Port checks for the starter register logic.
   Bound to motor_starter_regs; save hold-off of at least 8 cycles. */
`timescale 1ns/1ps
module motor_starter_regs_asserts (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic [7:0] tx_data, // Reply byte
  input wire logic tx_valid, // Reply valid
  input wire logic tx_ready, // Reply taken
  input wire logic rx_blocked, // Hold-off
  input wire logic turn_clockwise, // Run cw
  input wire logic turn_anticlockwise, // Run acw
  input wire logic device_reset, // Reset pulse
  input wire logic save_config, // Save pulse
  input wire logic [6:0] slave_address, // Own address
  input wire logic ee_load_valid, // Load strobe
  input wire logic fault_valid, // Fault strobe
  input wire logic [3:0] fault_code // Fault code
);
  // Once the stored set has arrived the switches must be ignored.
  logic init_done_ff;
  always_ff @(posedge clk_sys)
    init_done_ff <= !rst && (init_done_ff || ee_load_valid);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_save; save_config; endsequence
  sequence s_held; rx_blocked [*8]; endsequence
  a_save_blocks: assert property (s_save |-> s_held)
    else $error("save without hold-off");
  a_save_pulse: assert property (save_config |=> !save_config)
    else $error("save pulse too long");
  a_save_after: assert property (save_config |-> !tx_valid)
    else $error("save before reply end");
  a_block_quiet: assert property (rx_blocked |-> !tx_valid)
    else $error("reply during hold-off");
  a_reset_pulse: assert property (device_reset |=> !device_reset)
    else $error("reset pulse too long");
  a_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("reply byte lost");
  a_fault_stop: assert property (fault_valid && fault_code != 4'h0
    |-> ##[1:2] (!turn_clockwise && !turn_anticlockwise))
    else $error("run after fault");
  a_addr_hold: assert property
    (init_done_ff |-> $stable(slave_address)) else $error("address moved");
endmodule : motor_starter_regs_asserts
////////////////////////////////////////////////////////////////////////////
bind motor_starter_regs motor_starter_regs_asserts
  motor_starter_regs_asserts_inst (.clk_sys, .rst, .tx_data, .tx_valid,
  .tx_ready, .rx_blocked, .turn_clockwise, .turn_anticlockwise,
  .device_reset, .save_config, .slave_address, .ee_load_valid,
  .fault_valid, .fault_code);

// ---- motor_starter_regs_tb.sv ----
/* Bench for the starter register logic; frames go through the master
   model. Assumes shortened hold-off and millisecond counts. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  err_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module motor_starter_regs_tb;
  logic clk_sys = 1'b0, rst = 1'b1, ee_load_valid = 1'b0;
  logic fault_valid = 1'b0, ee_load_bad = 1'b0;
  logic [3:0] tens = 4'h1, units = 4'h7, fault_code = 4'h8;
  logic [2:0] baud = 3'h5, motor_state = 3'h3, baud_rate_sel;
  logic [15:0] measured_current = 16'h0bb8, load_percent = 16'h0064;
  logic [79:0] ee_load_data = 80'h0014_0028_001e_003c_00fa;
  logic [79:0] config_data, save_data;
  logic [7:0] rx_data, tx_data, r[$];
  logic [6:0] slave_address;
  logic rx_valid, rx_frame_end, tx_valid, tx_ready, rx_blocked;
  logic turn_clockwise, turn_anticlockwise, device_reset, save_config;
  int err_count, total_checks, saves, resets;
  // Refused frames: function, address, value, exception code.
  logic [39:0] bad_tbl[11] = '{40'h06_01_0003_03, 40'h06_02_0031_03,
    40'h06_03_0051_03, 40'h06_04_0065_03, 40'h06_05_001d_03,
    40'h06_06_0065_03, 40'h05_00_1234_03, 40'h02_00_0001_01,
    40'h10_00_0001_03, 40'h06_09_0001_02, 40'h03_00_0000_03};
  motor_starter_regs #(.SAVE_HOLD_CYC(20), .CYC_PER_MS(10))
    motor_starter_regs_inst (.clk_sys, .rst, .address_tens_selector(tens),
    .address_units_selector(units), .baud_selector(baud), .baud_rate_sel,
    .slave_address, .rx_data, .rx_valid, .rx_frame_end, .tx_data, .tx_valid,
    .tx_ready, .rx_blocked, .turn_clockwise, .turn_anticlockwise,
    .device_reset, .save_config, .config_data, .ee_load_valid, .ee_load_bad,
    .ee_load_data, .fault_valid, .fault_code, .motor_state,
    .measured_current, .load_percent);
  modbus_master modbus_master_inst (.clk_sys, .rx_data, .rx_valid,
    .rx_frame_end, .tx_data, .tx_valid, .tx_ready);
  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) saves += int'(save_config === 1'b1);
  always @(posedge clk_sys) resets += int'(device_reset === 1'b1);
  always @(posedge clk_sys) if (save_config === 1'b1) save_data = config_data;
  task x(input logic [47:0] f);
    modbus_master_inst.xfer(f);
    r = modbus_master_inst.r;
  endtask : x
  task w(input int i, input logic [15:0] e);
    `CHK("word", e, {r[3+2*i], r[4+2*i]})
  endtask : w
  ////////////////////////////////////////////////////////////////////////
  task t_init;
    @(negedge clk_sys);
    ee_load_valid = 1'b1;
    @(negedge clk_sys);
    ee_load_valid = 1'b0;
    tens = 4'h0;
    `CHK("address", 7'h11, slave_address)
    `CHK("rate", 3'h5, baud_rate_sel)
    x(48'h11_03_0002_0005);
    for (int i = 0; i < 5; i++) w(i, ee_load_data[16*i +: 16]);
  endtask : t_init
  task t_coils;
    modbus_master_inst.slow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      x({24'h11_05_00, 7'h00, i[0], (i < 2) ? 16'hff00 : 16'h0000});
      `CHK("echo", 8, r.size())
      `CHK("cw", i < 2, turn_clockwise)
      `CHK("acw", i inside {1, 2}, turn_anticlockwise)
    end
    modbus_master_inst.slow = 1'b0;
  endtask : t_coils
  task t_reject;
    foreach (bad_tbl[i]) begin
      x({8'h11, bad_tbl[i][39:32], 8'h00, bad_tbl[i][31:8]});
      `CHK("exc", {bad_tbl[i][39:32] | 8'h80, bad_tbl[i][7:0]}, {r[1], r[2]})
    end
  endtask : t_reject
  task t_input;
    x(48'h11_04_0000_0004);
    w(0, 16'h0000);
    w(1, 16'h0003);
    w(2, 16'h0bb8);
    w(3, 16'h0064);
  endtask : t_input
  task t_save;
    x(48'h11_06_0002_00c8);
    x(48'h11_05_0003_0000);
    `CHK("saves", 0, saves)
    x(48'h11_05_0003_ff00);
    `CHK("saves", 1, saves)
    `CHK("saved", {ee_load_data[79:16], 16'h00c8}, save_data)
    x(48'h11_06_0000_0002);
    `CHK("saves", 2, saves)
  endtask : t_save
  task t_fault;
    x(48'h11_05_0000_ff00);
    fault_valid = 1'b1;
    @(negedge clk_sys);
    fault_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
    `CHK("cw", 1'b0, turn_clockwise)
    x(48'h11_04_0000_0002);
    w(0, 16'h0008);
    w(1, 16'h0006);
    x(48'h11_05_0002_ff00);
    `CHK("resets", 1, resets)
    x(48'h11_04_0000_0001);
    w(0, 16'h0000);
    x(48'h11_06_0008_0001);
    x(48'h11_06_0007_0001);
    x(48'h11_04_0000_0001);
    w(0, 16'h0009);
  endtask : t_fault
  task finish_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    t_init();
    t_coils();
    t_reject();
    t_input();
    t_save();
    t_fault();
    finish_test();
  end
  initial begin
    #(15000 * 100);
    err_count++;
    finish_test();
  end
endmodule : motor_starter_regs_tb

// ---- starter_pkg.sv ----
/*
 * Shared constants and types for the motor starter register logic.
 * Assumes a 10 MHz system clock and byte-level frame framing done by an
 * external character receiver and transmitter.
 */
package starter_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned SAVE_HOLD_MS = 50;
  localparam int unsigned SAVE_HOLD_CYC = SAVE_HOLD_MS * CYC_PER_MS;

  localparam int unsigned N_HOLD = 9;
  localparam int unsigned N_INPUT = 4;
  localparam int unsigned N_SAVED = 5;
  localparam int unsigned RX_DEPTH = 32;
  localparam logic [15:0] HOLD_COUNT = 16'(N_HOLD);
  localparam logic [15:0] INPUT_COUNT = 16'(N_INPUT);
  localparam logic [15:0] COIL_COUNT = 16'h0004;

  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] FC_WR_MULTI = 8'h10;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] EXC_FLAG = 8'h80;

  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [1:0] COIL_CW = 2'h0;
  localparam logic [1:0] COIL_ACW = 2'h1;
  localparam logic [1:0] COIL_RESET = 2'h2;
  localparam logic [1:0] COIL_SAVE = 2'h3;

  localparam logic [3:0] HR_SYS = 4'h0;
  localparam logic [3:0] HR_RUN = 4'h1;
  localparam logic [3:0] HR_CUR = 4'h2;
  localparam logic [3:0] HR_UPV = 4'h3;
  localparam logic [3:0] HR_UPT = 4'h4;
  localparam logic [3:0] HR_DNV = 4'h5;
  localparam logic [3:0] HR_DNT = 4'h6;
  localparam logic [3:0] HR_TOE = 4'h7;
  localparam logic [3:0] HR_TOV = 4'h8;
  localparam int unsigned SYS_RESET_BIT = 0;
  localparam int unsigned SYS_SAVE_BIT = 1;
  localparam int unsigned RUN_CW_BIT = 0;
  localparam int unsigned RUN_ACW_BIT = 1;

  localparam logic [15:0] CTRL_MAX = 16'h0002;
  localparam logic [15:0] CUR_MIN = 16'h0032;
  localparam logic [15:0] CUR_MAX = 16'h01f4;
  localparam logic [15:0] VOLT_MIN = 16'h001e;
  localparam logic [15:0] VOLT_MAX = 16'h0050;
  localparam logic [15:0] TIME_MAX = 16'h0064;
  localparam logic [15:0] TOE_MAX = 16'h0001;
  localparam logic [15:0] TOV_MAX = 16'h2710;

  // Reset values; registers 2..6 are replaced when the stored configuration arrives with a good checksum at power-up.
  localparam logic [N_HOLD-1:0][15:0] HREG_RST = {
    16'h03e8, 16'h0000, 16'h000a, 16'h001e, 16'h000a,
    16'h001e, 16'h0064, 16'h0000, 16'h0000};

  localparam logic [3:0] FAIL_NONE = 4'h0;
  localparam logic [3:0] FAIL_LINK = 4'h9;
  localparam logic [3:0] FAIL_EEPROM = 4'ha;
  localparam logic [15:0] STATE_ERROR = 16'h0006;

  localparam logic [6:0] ADDR_MIN = 7'h01;
  localparam logic [6:0] ADDR_MAX = 7'h63;
  localparam logic [7:0] ADDR_TENS_SCALE = 8'h0a;

  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [5:0] FRAME_MIN = 6'h04;
  localparam logic [5:0] MULTI_HDR = 6'h07;
  localparam logic [5:0] MULTI_FIX = 6'h09;
  localparam logic [5:0] READ_HDR = 6'h03;
  localparam logic [5:0] ECHO_LEN = 6'h06;
  localparam logic [5:0] EXC_LEN = 6'h03;

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_IDLE = 3'b001,
    ST_CHECK = 3'b010,
    ST_EXEC = 3'b011,
    ST_RESP = 3'b100,
    ST_BLOCK = 3'b101
  } phase_t;

endpackage : starter_pkg
